/* logic/crf_pkg.sv */
package crf_pkg;

	// Register addresses on the plain register port
	localparam logic [7:0] CRF_ADDR_FLAGS = 8'h04;
	localparam logic [7:0] CRF_ADDR_IRQ_ENABLE = 8'h05;

	// Field positions shared by the flag and enable registers
	localparam int CRF_BIT_WAKEUP = 7;
	localparam int CRF_BIT_STATUS_CHANGE = 6;
	localparam int CRF_BIT_RX_HI = 5;
	localparam int CRF_BIT_RX_LO = 4;
	localparam int CRF_BIT_TX_HI = 3;
	localparam int CRF_BIT_TX_LO = 2;
	localparam int CRF_BIT_OVERRUN = 1;
	localparam int CRF_BIT_RECEIVE_FULL = 0;

	// Reset values
	localparam logic [7:0] CRF_RESET_BYTE = 8'h00;
	localparam logic [1:0] CRF_RESET_SENS = 2'h0;

	// Error counter thresholds
	localparam logic [8:0] CRF_WARN_LIMIT = 9'h060;
	localparam logic [8:0] CRF_ERR_LIMIT = 9'h07F;
	localparam logic [8:0] CRF_BUSOFF_LIMIT = 9'h0FF;

	// Bus state encodings of the state fields
	typedef enum logic [1:0]
	{
		CRF_STATE_OK = 2'h0,
		CRF_STATE_WARNING = 2'h1,
		CRF_STATE_ERROR = 2'h2,
		CRF_STATE_BUSOFF = 2'h3
	} crf_bus_state_t;

	// Sensitivity settings of the status-change enables
	typedef enum logic [1:0]
	{
		CRF_SENS_NONE = 2'h0,
		CRF_SENS_BUSOFF = 2'h1,
		CRF_SENS_ERROR = 2'h2,
		CRF_SENS_ALL = 2'h3
	} crf_sens_t;

	// Number of write-one-to-clear flags
	localparam int CRF_NUM_FLAGS = 4;

endpackage

/* logic/crf_state_encode.sv */
`timescale 1ns/1ps
`default_nettype none
module crf_state_encode
	import crf_pkg::*;
(
	input wire logic [8:0] i_tec,
	input wire logic [7:0] i_rec,
	input wire logic [1:0] i_rx_state,
	output logic [1:0] o_rx_enc,
	output logic [1:0] o_tx_enc
);

	logic [8:0] rec_wide;

	assign rec_wide = {1'b0, i_rec};

	// Transmitter state straight from the transmit count
	always_comb
	begin
		if (i_tec > CRF_BUSOFF_LIMIT)
			o_tx_enc = CRF_STATE_BUSOFF;
		else if (i_tec > CRF_ERR_LIMIT)
			o_tx_enc = CRF_STATE_ERROR;
		else if (i_tec >= CRF_WARN_LIMIT)
			o_tx_enc = CRF_STATE_WARNING;
		else
			o_tx_enc = CRF_STATE_OK;
	end

	// Receiver state; bus-off comes from the transmit count
	always_comb
	begin
		if (i_tec > CRF_BUSOFF_LIMIT)
			o_rx_enc = CRF_STATE_BUSOFF;
		else if (i_rx_state == CRF_STATE_BUSOFF)
			o_rx_enc = CRF_STATE_OK;
		else if (rec_wide > CRF_ERR_LIMIT)
			o_rx_enc = CRF_STATE_ERROR;
		else if (rec_wide > CRF_WARN_LIMIT)
			o_rx_enc = CRF_STATE_WARNING;
		else
			o_rx_enc = CRF_STATE_OK;
	end

endmodule
`default_nettype wire

/* logic/crf_change_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module crf_change_detect
	import crf_pkg::*;
(
	input wire logic [1:0] i_rx_old,
	input wire logic [1:0] i_rx_new,
	input wire logic [1:0] i_tx_old,
	input wire logic [1:0] i_tx_new,
	input wire logic [1:0] i_rx_sens,
	input wire logic [1:0] i_tx_sens,
	output logic o_trigger
);

	// Does a move from old to new matter at this sensitivity
	function automatic logic sens_hit(input logic [1:0] old_s, input logic [1:0] new_s,
		input logic [1:0] sens);
		logic hit;
		hit = 1'b0;
		case (sens)
			CRF_SENS_NONE: hit = 1'b0;
			CRF_SENS_BUSOFF: hit = (old_s == CRF_STATE_BUSOFF) != (new_s == CRF_STATE_BUSOFF);
			CRF_SENS_ERROR: hit = (old_s >= CRF_STATE_ERROR) != (new_s >= CRF_STATE_ERROR);
			CRF_SENS_ALL: hit = (old_s != new_s);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Either side may raise the status-change event
	always_comb
	begin
		o_trigger = sens_hit(i_rx_old, i_rx_new, i_rx_sens) |
			sens_hit(i_tx_old, i_tx_new, i_tx_sens);
	end

endmodule
`default_nettype wire

/* logic/crf_rx_flags.sv */
`timescale 1ns/1ps
`default_nettype none
module crf_rx_flags
	import crf_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	input wire logic I_INIT_MODE_REQUEST,
	input wire logic I_INIT_MODE_ACKNOWLEDGE,
	input wire logic I_SLEEP_MODE,
	input wire logic I_BUS_ACTIVITY,
	input wire logic I_WAKEUP_ENABLE,
	input wire logic [8:0] I_TRANSMIT_ERROR_COUNT,
	input wire logic [7:0] I_RECEIVE_ERROR_COUNT,
	input wire logic I_OVERRUN,
	input wire logic I_FIFO_NOT_EMPTY,
	output logic O_SHIFT_FOREGROUND,
	output logic O_WAKEUP_IRQ,
	output logic O_ERROR_IRQ,
	output logic O_RECEIVE_IRQ,
	output logic [1:0] O_RECEIVER_STATE,
	output logic [1:0] O_TRANSMITTER_STATE
);

	// Flag vector order inside this module
	localparam int F_WAKE = 3;
	localparam int F_CSC = 2;
	localparam int F_OVR = 1;
	localparam int F_RXF = 0;

	// Map a flag index to its bit in the register byte
	function automatic int flag_pos(input int idx);
		int pos;
		pos = CRF_BIT_RECEIVE_FULL;
		case (idx)
			F_WAKE: pos = CRF_BIT_WAKEUP;
			F_CSC: pos = CRF_BIT_STATUS_CHANGE;
			F_OVR: pos = CRF_BIT_OVERRUN;
			default: pos = CRF_BIT_RECEIVE_FULL;
		endcase
		return pos;
	endfunction

	logic in_init;
	logic out_of_init;
	logic wr_flags;
	logic wr_enable;
	logic [CRF_NUM_FLAGS-1:0] flag_set;
	logic [CRF_NUM_FLAGS-1:0] flag_clear;
	logic [CRF_NUM_FLAGS-1:0] flag_reg;
	logic [CRF_NUM_FLAGS-1:0] irq_en_reg;
	logic [1:0] rx_sens_reg;
	logic [1:0] tx_sens_reg;
	logic [1:0] rx_state_reg;
	logic [1:0] tx_state_reg;
	logic [1:0] rx_enc;
	logic [1:0] tx_enc;
	logic state_trigger;
	logic state_moved;
	logic shift_next;
	logic [7:0] flags_byte;
	logic [7:0] enable_byte;
	logic [7:0] rdata_next;

	// Init mode needs both handshake bits; writes need both low
	assign in_init = I_INIT_MODE_REQUEST & I_INIT_MODE_ACKNOWLEDGE;
	assign out_of_init = ~I_INIT_MODE_REQUEST & ~I_INIT_MODE_ACKNOWLEDGE;
	assign wr_flags = I_WR & out_of_init & (I_ADDR == CRF_ADDR_FLAGS);
	assign wr_enable = I_WR & out_of_init & (I_ADDR == CRF_ADDR_IRQ_ENABLE);

	// Error counters to bus states
	crf_state_encode u_encode
	(
		.i_tec(I_TRANSMIT_ERROR_COUNT),
		.i_rec(I_RECEIVE_ERROR_COUNT),
		.i_rx_state(rx_state_reg),
		.o_rx_enc(rx_enc),
		.o_tx_enc(tx_enc)
	);

	// Which state moves count as a status change
	crf_change_detect u_detect
	(
		.i_rx_old(rx_state_reg),
		.i_rx_new(rx_enc),
		.i_tx_old(tx_state_reg),
		.i_tx_new(tx_enc),
		.i_rx_sens(rx_sens_reg),
		.i_tx_sens(tx_sens_reg),
		.o_trigger(state_trigger)
	);

	// A state move is taken only while no status change is pending
	assign state_moved = ~flag_reg[F_CSC] & ((rx_enc != rx_state_reg) | (tx_enc != tx_state_reg));

	// Foreground load: one shift per free buffer
	assign shift_next = I_FIFO_NOT_EMPTY & ~flag_reg[F_RXF] & ~in_init & ~O_SHIFT_FOREGROUND;

	// Set sources of each flag
	always_comb
	begin
		flag_set = '0;
		flag_set[F_WAKE] = I_SLEEP_MODE & I_BUS_ACTIVITY & I_WAKEUP_ENABLE;
		flag_set[F_CSC] = state_moved & state_trigger;
		flag_set[F_OVR] = I_OVERRUN;
		flag_set[F_RXF] = shift_next;
	end

	// Write-one-to-clear decode; the state bits have no clear path
	generate
		for (genvar g = 0; g < CRF_NUM_FLAGS; g++)
		begin : g_flag
			assign flag_clear[g] = wr_flags & I_WDATA[flag_pos(g)];

			// Set wins over a clear in the same cycle, so no event is lost
			always_ff @(posedge I_CLK_SYS)
			begin
				if (I_RESET | in_init)
					flag_reg[g] <= 1'b0;
				else if (flag_set[g])
					flag_reg[g] <= 1'b1;
				else if (flag_clear[g])
					flag_reg[g] <= 1'b0;
			end
		end
	endgenerate

	// State fields follow the counters in every mode, frozen while pending
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RESET)
		begin
			rx_state_reg <= CRF_STATE_OK;
			tx_state_reg <= CRF_STATE_OK;
		end
		else if (state_moved)
		begin
			rx_state_reg <= rx_enc;
			tx_state_reg <= tx_enc;
		end
	end

	// Interrupt enables are cleared in init mode
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RESET | in_init)
			irq_en_reg <= '0;
		else if (wr_enable)
		begin
			irq_en_reg[F_WAKE] <= I_WDATA[CRF_BIT_WAKEUP];
			irq_en_reg[F_CSC] <= I_WDATA[CRF_BIT_STATUS_CHANGE];
			irq_en_reg[F_OVR] <= I_WDATA[CRF_BIT_OVERRUN];
			irq_en_reg[F_RXF] <= I_WDATA[CRF_BIT_RECEIVE_FULL];
		end
	end

	// Sensitivities survive init mode so status tracking stays configured
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RESET)
		begin
			rx_sens_reg <= CRF_RESET_SENS;
			tx_sens_reg <= CRF_RESET_SENS;
		end
		else if (wr_enable)
		begin
			rx_sens_reg <= I_WDATA[CRF_BIT_RX_HI:CRF_BIT_RX_LO];
			tx_sens_reg <= I_WDATA[CRF_BIT_TX_HI:CRF_BIT_TX_LO];
		end
	end

	// Foreground shift strobe, one cycle
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RESET)
			O_SHIFT_FOREGROUND <= 1'b0;
		else
			O_SHIFT_FOREGROUND <= shift_next;
	end

	// Interrupt requests are registered, one cycle behind the flags
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RESET)
		begin
			O_WAKEUP_IRQ <= 1'b0;
			O_ERROR_IRQ <= 1'b0;
			O_RECEIVE_IRQ <= 1'b0;
		end
		else
		begin
			O_WAKEUP_IRQ <= flag_reg[F_WAKE] & irq_en_reg[F_WAKE];
			O_ERROR_IRQ <= (flag_reg[F_CSC] & irq_en_reg[F_CSC]) |
				(flag_reg[F_OVR] & irq_en_reg[F_OVR]);
			O_RECEIVE_IRQ <= flag_reg[F_RXF] & irq_en_reg[F_RXF];
		end
	end

	// State field outputs mirror the frozen fields
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RESET)
		begin
			O_RECEIVER_STATE <= CRF_STATE_OK;
			O_TRANSMITTER_STATE <= CRF_STATE_OK;
		end
		else
		begin
			O_RECEIVER_STATE <= rx_state_reg;
			O_TRANSMITTER_STATE <= tx_state_reg;
		end
	end

	// Register images for readback
	always_comb
	begin
		flags_byte = CRF_RESET_BYTE;
		flags_byte[CRF_BIT_WAKEUP] = flag_reg[F_WAKE];
		flags_byte[CRF_BIT_STATUS_CHANGE] = flag_reg[F_CSC];
		flags_byte[CRF_BIT_RX_HI:CRF_BIT_RX_LO] = rx_state_reg;
		flags_byte[CRF_BIT_TX_HI:CRF_BIT_TX_LO] = tx_state_reg;
		flags_byte[CRF_BIT_OVERRUN] = flag_reg[F_OVR];
		flags_byte[CRF_BIT_RECEIVE_FULL] = flag_reg[F_RXF];
		enable_byte = CRF_RESET_BYTE;
		enable_byte[CRF_BIT_WAKEUP] = irq_en_reg[F_WAKE];
		enable_byte[CRF_BIT_STATUS_CHANGE] = irq_en_reg[F_CSC];
		enable_byte[CRF_BIT_RX_HI:CRF_BIT_RX_LO] = rx_sens_reg;
		enable_byte[CRF_BIT_TX_HI:CRF_BIT_TX_LO] = tx_sens_reg;
		enable_byte[CRF_BIT_OVERRUN] = irq_en_reg[F_OVR];
		enable_byte[CRF_BIT_RECEIVE_FULL] = irq_en_reg[F_RXF];
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_next = CRF_RESET_BYTE;
		if (I_RD)
		begin
			case (I_ADDR)
				CRF_ADDR_FLAGS: rdata_next = flags_byte;
				CRF_ADDR_IRQ_ENABLE: rdata_next = enable_byte;
				default: rdata_next = CRF_RESET_BYTE;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RESET)
			O_RDATA <= CRF_RESET_BYTE;
		else
			O_RDATA <= rdata_next;
	end

endmodule
`default_nettype wire

/* testbench/crf_fifo_model.sv */
`timescale 1ns/1ps
`default_nettype none
module crf_fifo_model
(
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_push,
	input wire logic i_shift,
	output logic o_not_empty,
	output logic [3:0] o_shifts
);
	logic [3:0] level_reg;
	// Receive queue behind the foreground buffer; each shift pops one message
	always_ff @(posedge i_clk)
	begin
		if (i_reset)
		begin
			level_reg <= 4'h0;
			o_shifts <= 4'h0;
		end
		else
		begin
			level_reg <= level_reg + 4'(i_push) - 4'(i_shift);
			o_shifts <= o_shifts + 4'(i_shift);
		end
	end
	assign o_not_empty = level_reg != 4'h0;
endmodule
`default_nettype wire

/* testbench/crf_rx_flags_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module crf_rx_flags_monitor
	import crf_pkg::*;
(
	input wire logic I_CLK_SYS,
	input wire logic I_RESET,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_INIT_MODE_REQUEST,
	input wire logic I_INIT_MODE_ACKNOWLEDGE,
	input wire logic I_OVERRUN,
	input wire logic I_FIFO_NOT_EMPTY,
	input wire logic O_SHIFT_FOREGROUND,
	input wire logic O_WAKEUP_IRQ,
	input wire logic O_ERROR_IRQ,
	input wire logic O_RECEIVE_IRQ
);
	logic init_on;
	logic wr_ok;
	logic [7:0] en_reg;
	assign init_on = I_INIT_MODE_REQUEST && I_INIT_MODE_ACKNOWLEDGE;
	assign wr_ok = I_WR && !(I_INIT_MODE_REQUEST || I_INIT_MODE_ACKNOWLEDGE);
	// Shadow of the enable register; init keeps only the sensitivities
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_RESET)
			en_reg <= 8'h00;
		else if (init_on)
			en_reg <= en_reg & 8'h3C;
		else if (wr_ok && I_ADDR == CRF_ADDR_IRQ_ENABLE)
			en_reg <= I_WDATA;
	end
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (I_RESET);
	// A shift needs a waiting message and never comes in the cycle right after another shift
	AST_SHIFT_SRC: assert property (O_SHIFT_FOREGROUND |-> $past(I_FIFO_NOT_EMPTY))
		else $error("shift without message");
	AST_SHIFT_GAP: assert property (O_SHIFT_FOREGROUND |=> !O_SHIFT_FOREGROUND)
		else $error("shift while buffer full");
	AST_SHIFT_INIT: assert property (init_on |=> !O_SHIFT_FOREGROUND)
		else $error("shift in init");
	// Requests follow their flag one cycle late and obey the mask
	AST_OVR_IRQ: assert property ((I_OVERRUN && en_reg[1] && !init_on) ##1 !(I_WR || init_on)
		|=> O_ERROR_IRQ)
		else $error("overrun request missing");
	AST_RX_IRQ: assert property (O_SHIFT_FOREGROUND && en_reg[0] && !init_on && !I_WR
		|=> O_RECEIVE_IRQ)
		else $error("receive request missing");
	AST_RX_MASK: assert property (!en_reg[0] |=> !O_RECEIVE_IRQ)
		else $error("masked receive request");
	AST_WAKE_MASK: assert property (!en_reg[7] |=> !O_WAKEUP_IRQ)
		else $error("masked wake-up request");
	AST_ERR_MASK: assert property (!(en_reg[6] || en_reg[1]) |=> !O_ERROR_IRQ)
		else $error("masked error request");
	cover property (O_SHIFT_FOREGROUND ##2 O_SHIFT_FOREGROUND);
	cover property (O_ERROR_IRQ ##1 !O_ERROR_IRQ);
	cover property (O_WAKEUP_IRQ);
endmodule
bind crf_rx_flags crf_rx_flags_monitor i_mon (.*);
`default_nettype wire

/* testbench/crf_rx_flags_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module crf_rx_flags_bench import crf_pkg::*;;
	logic clk = 0, rst = 1, wr = 0, rd = 0, req = 0, ack = 0, sleep = 0, act = 0;
	logic wen = 0, ovr = 0, push = 0, pend = 0;
	logic fne, shf, wirq, eirq, rirq;
	logic [7:0] addr = 8'h00, wdata = 8'h00, receive_error_count = 8'h00, rdata;
	logic [8:0] transmit_error_count = 9'h000;
	logic [1:0] rxs, txs;
	logic [3:0] shifts, fr = 4'h0;
	logic [8:0] ct [6] = '{9'h060, 9'h05F, 9'h07F, 9'h080, 9'h0FF, 9'h100};
	logic [7:0] cr [6] = '{8'h60, 8'h61, 8'h7F, 8'h80, 8'h00, 8'hFF};
	int error_cnt = 0, checks = 0, seed = 32'h92e17547;
	always #2 clk = ~clk;
	crf_rx_flags i_dut (.I_CLK_SYS(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_INIT_MODE_REQUEST(req),
		.I_INIT_MODE_ACKNOWLEDGE(ack), .I_SLEEP_MODE(sleep), .I_BUS_ACTIVITY(act),
		.I_WAKEUP_ENABLE(wen), .I_TRANSMIT_ERROR_COUNT(transmit_error_count), .I_RECEIVE_ERROR_COUNT(receive_error_count),
		.I_OVERRUN(ovr), .I_FIFO_NOT_EMPTY(fne), .O_SHIFT_FOREGROUND(shf), .O_WAKEUP_IRQ(wirq),
		.O_ERROR_IRQ(eirq), .O_RECEIVE_IRQ(rirq), .O_RECEIVER_STATE(rxs),
		.O_TRANSMITTER_STATE(txs));
	crf_fifo_model i_fifo (.i_clk(clk), .i_reset(rst), .i_push(push), .i_shift(shf),
		.o_not_empty(fne), .o_shifts(shifts));
	// Fields the counters ask for; receiver drops to OK when bus-off ends
	function automatic logic [3:0] want(input logic [3:0] f);
		logic [1:0] tx;
		logic [1:0] rx;
		tx = transmit_error_count > 9'h0FF ? 2'h3 : transmit_error_count > 9'h07F ? 2'h2 : transmit_error_count > 9'h05F ? 2'h1 : 2'h0;
		rx = tx == 2'h3 ? 2'h3 : receive_error_count > 8'h7F ? 2'h2 : receive_error_count > 8'h60 ? 2'h1 : 2'h0;
		if (f[3:2] == 2'h3 && tx != 2'h3)
			rx = 2'h0;
		return {rx, tx};
	endfunction
	// Fields load only while no status change is pending
	task automatic upd();
		if (!pend && want(fr) !== fr)
		begin
			fr = want(fr);
			pend = 1;
		end
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task automatic mode(input logic r, input logic k);
		@(posedge clk);
		req <= r;
		ack <= k;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rchk(CRF_ADDR_FLAGS, CRF_RESET_BYTE);
		rchk(8'h07, 8'h00);
		// Writes are dropped in init and with the init bits mixed
		mode(1, 1);
		wr_reg(CRF_ADDR_IRQ_ENABLE, 8'hFF);
		rchk(CRF_ADDR_IRQ_ENABLE, 8'h00);
		mode(1, 0);
		wr_reg(CRF_ADDR_IRQ_ENABLE, 8'hFF);
		rchk(CRF_ADDR_IRQ_ENABLE, 8'h00);
		mode(0, 0);
		wr_reg(CRF_ADDR_IRQ_ENABLE, 8'hFF);
		rchk(CRF_ADDR_IRQ_ENABLE, 8'hFF);
		// Overrun, then a clear that loses to a new overrun
		@(posedge clk);
		ovr <= 1'b1;
		@(posedge clk);
		ovr <= 1'b0;
		repeat (2) @(negedge clk);
		chk({7'h00, eirq}, 8'h01);
		wr_reg(CRF_ADDR_FLAGS, 8'hFD);
		rchk(CRF_ADDR_FLAGS, 8'h02);
		@(posedge clk);
		ovr <= 1'b1;
		wr_reg(CRF_ADDR_FLAGS, 8'h02);
		ovr <= 1'b0;
		rchk(CRF_ADDR_FLAGS, 8'h02);
		wr_reg(CRF_ADDR_FLAGS, 8'h02);
		rchk(CRF_ADDR_FLAGS, 8'h00);
		// Bus activity in sleep wakes the block
		@(posedge clk);
		sleep <= 1'b1;
		wen <= 1'b1;
		act <= 1'b1;
		@(posedge clk);
		act <= 1'b0;
		repeat (2) @(negedge clk);
		chk({7'h00, wirq}, 8'h01);
		rchk(CRF_ADDR_FLAGS, 8'h80);
		// Two messages: the second waits until the first is released
		@(posedge clk);
		push <= 1'b1;
		repeat (2) @(posedge clk);
		push <= 1'b0;
		repeat (4) @(negedge clk);
		chk({4'h0, shifts}, 8'h01);
		chk({7'h00, rirq}, 8'h01);
		rchk(CRF_ADDR_FLAGS, 8'h81);
		wr_reg(CRF_ADDR_FLAGS, 8'h81);
		repeat (4) @(negedge clk);
		chk({4'h0, shifts}, 8'h02);
		// Counter walk: corners first, then random counts
		for (int i = 0; i < 30; i++)
		begin
			@(posedge clk);
			transmit_error_count <= i < 6 ? ct[i] : 9'({$random(seed)} % 300);
			receive_error_count <= i < 6 ? cr[i] : 8'($random(seed));
			repeat (3) @(negedge clk);
			upd();
			rchk(CRF_ADDR_FLAGS, {1'b0, pend, fr, 2'b01});
			// Ones written to the state bits must not disturb them
			wr_reg(CRF_ADDR_FLAGS, 8'h7C);
			pend = 0;
			repeat (3) @(negedge clk);
			upd();
			rchk(CRF_ADDR_FLAGS, {1'b0, pend, fr, 2'b01});
			chk({4'h0, rxs, txs}, {4'h0, fr});
		end
		// Init clears the flags while the fields keep tracking
		mode(1, 1);
		transmit_error_count <= 9'h005;
		receive_error_count <= 8'h70;
		repeat (8) @(negedge clk);
		rchk(CRF_ADDR_FLAGS, 8'h10);
		mode(0, 0);
		rchk(CRF_ADDR_IRQ_ENABLE, 8'h3C);
		// Sensitivity settings decide which moves raise a status change
		wr_reg(CRF_ADDR_IRQ_ENABLE, 8'h00);
		transmit_error_count <= 9'h062;
		repeat (3) @(negedge clk);
		rchk(CRF_ADDR_FLAGS, 8'h14);
		wr_reg(CRF_ADDR_IRQ_ENABLE, 8'h14);
		transmit_error_count <= 9'h080;
		repeat (3) @(negedge clk);
		rchk(CRF_ADDR_FLAGS, 8'h18);
		transmit_error_count <= 9'h100;
		repeat (3) @(negedge clk);
		rchk(CRF_ADDR_FLAGS, 8'h7C);
		wr_reg(CRF_ADDR_FLAGS, 8'h40);
		wr_reg(CRF_ADDR_IRQ_ENABLE, 8'h28);
		transmit_error_count <= 9'h005;
		repeat (3) @(negedge clk);
		rchk(CRF_ADDR_FLAGS, 8'h40);
		wr_reg(CRF_ADDR_FLAGS, 8'h40);
		repeat (3) @(negedge clk);
		rchk(CRF_ADDR_FLAGS, 8'h10);
		print_verdict();
	end
	// Cuts a hang short far beyond the expected run length
	initial
	begin
		#100000;
		error_cnt++;
		print_verdict();
	end
endmodule
`default_nettype wire
